// *** plpd_top.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "plpd_defines.svh"

module plpd_top (
    input wire logic clk_sys,
    input wire logic sys_rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // oscillator inputs
    input wire logic high_band_osc_input,
    input wire logic low_band_osc_input,
    // serial link
    input wire logic serial_clock_pin,
    input wire logic chip_enable_pin,
    input wire logic serial_in_pin,
    output logic serial_out_o,
    output logic serial_out_oe_n,
    // divider output toward phase comparison
    output logic div_pulse
);

    // ==========================================================
    // declarations
    logic rst_l1_q;
    logic rst_l2_q;
    logic [7:0] addr_sr_q;
    logic [4:0] bit_cnt_q;
    logic [23:0] data_sr_q;
    logic [23:0] hold_q;
    logic hold_sel_q;
    logic done_tgl_q;
    logic [7:0] addr_label;
    logic link_in;
    logic link_out_active;
    logic out_bit;
    logic tg1_q;
    logic tg2_q;
    logic tg3_q;
    logic word_arrived;
    plpd_pkg::plpd_ctrl1_t ctrl1_q;
    logic [23:0] ctrl2_q;
    logic [23:0] out_word_q;
    plpd_pkg::plpd_statin_t statin_q;
    logic doc_low_q;
    logic doc_low_d;
    logic [2:0] doc_sel;
    logic hb1_q;
    logic hb2_q;
    logic hb3_q;
    logic lb1_q;
    logic lb2_q;
    logic lb3_q;
    logic hb_edge;
    logic lb_edge;
    logic pre_q;
    logic tick;
    plpd_pkg::plpd_divcfg_t cfg;
    logic pulse;
    logic [31:0] pulse_cnt_q;
    logic [7:0] frames_q;
    logic apb_wr;
    logic apb_rd;
    logic mapped;
    logic [31:0] rdata_d;

    // ==========================================================
    // link domain reset from the system reset
    always_ff @(posedge serial_clock_pin) begin
        rst_l1_q <= sys_rst;
        rst_l2_q <= rst_l1_q;
    end

    // address in label form and mode decode
    assign addr_label = {addr_sr_q[3:0], addr_sr_q[7:4]};
    assign link_in = (addr_label == `PLPD_ADDR_IN1) ||
                     (addr_label == `PLPD_ADDR_IN2);

    // ==========================================================
    // address shift while enable is low, bits b0 first
    always_ff @(posedge serial_clock_pin) begin
        if (rst_l2_q) begin
            addr_sr_q <= 8'h00;
        end else if (!chip_enable_pin) begin
            addr_sr_q <= {serial_in_pin, addr_sr_q[7:1]};
        end
    end

    // bit counter runs only while enable is high
    always_ff @(posedge serial_clock_pin) begin
        if (rst_l2_q) begin
            bit_cnt_q <= 5'h00;
        end else if (!chip_enable_pin) begin
            bit_cnt_q <= 5'h00;
        end else if (bit_cnt_q != `PLPD_DATA_BITS) begin
            bit_cnt_q <= bit_cnt_q + 5'h01;
        end
    end

    // ==========================================================
    // control data shift, first bit ends in bit 0
    always_ff @(posedge serial_clock_pin) begin
        if (rst_l2_q) begin
            data_sr_q <= 24'h000000;
        end else if (chip_enable_pin && link_in &&
                     bit_cnt_q != `PLPD_DATA_BITS) begin
            data_sr_q <= {serial_in_pin, data_sr_q[23:1]};
        end
    end

    // word complete on the 24th bit: hold it and flag it
    always_ff @(posedge serial_clock_pin) begin
        if (rst_l2_q) begin
            hold_q <= 24'h000000;
            hold_sel_q <= 1'b0;
            done_tgl_q <= 1'b0;
        end else if (chip_enable_pin && link_in &&
                     bit_cnt_q == `PLPD_DATA_LAST) begin
            hold_q <= {serial_in_pin, data_sr_q[23:1]};
            hold_sel_q <= (addr_label == `PLPD_ADDR_IN2);
            done_tgl_q <= ~done_tgl_q;
        end
    end

    // ==========================================================
    // serial output: data word msb first in out mode, else function
    assign link_out_active = chip_enable_pin &&
                             (addr_label == `PLPD_ADDR_OUT) &&
                             (bit_cnt_q != `PLPD_DATA_BITS);
    assign out_bit = out_word_q[5'd23 - bit_cnt_q];
    assign serial_out_o = 1'b0;
    assign serial_out_oe_n = link_out_active ? out_bit : ~doc_low_q;

    // ==========================================================
    // word toggle crossing into the system domain
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            tg1_q <= 1'b0;
            tg2_q <= 1'b0;
            tg3_q <= 1'b0;
        end else begin
            tg1_q <= done_tgl_q;
            tg2_q <= tg1_q;
            tg3_q <= tg2_q;
        end
    end

    assign word_arrived = tg2_q ^ tg3_q;

    // control words, defaults at reset
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ctrl1_q <= `PLPD_CTRL1_RST;
            ctrl2_q <= `PLPD_CTRL2_RST;
        end else if (word_arrived) begin
            if (hold_sel_q) begin
                ctrl2_q <= hold_q;
            end else begin
                ctrl1_q <= hold_q;
            end
        end
    end

    // count of control words received
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            frames_q <= 8'h00;
        end else if (word_arrived) begin
            frames_q <= frames_q + 8'h01;
        end
    end

    // ==========================================================
    // out pin function select
    assign doc_sel = ctrl2_q[`PLPD_IN2_DOC_MSB:`PLPD_IN2_DOC_LSB];

    always_comb begin
        unique case (doc_sel)
            `PLPD_DOC_UNLOCK: doc_low_d = statin_q.unlock;
            `PLPD_DOC_DONE: doc_low_d = statin_q.count_done;
            `PLPD_DOC_LPIN: doc_low_d = ~statin_q.low_pin;
            `PLPD_DOC_IOPIN: doc_low_d = ~statin_q.io_pin;
            default: doc_low_d = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            doc_low_q <= 1'b0;
        end else begin
            doc_low_q <= doc_low_d;
        end
    end

    // ==========================================================
    // oscillator synchronisers and edge detect
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            hb1_q <= 1'b0;
            hb2_q <= 1'b0;
            hb3_q <= 1'b0;
            lb1_q <= 1'b0;
            lb2_q <= 1'b0;
            lb3_q <= 1'b0;
        end else begin
            hb1_q <= high_band_osc_input;
            hb2_q <= hb1_q;
            hb3_q <= hb2_q;
            lb1_q <= low_band_osc_input;
            lb2_q <= lb1_q;
            lb3_q <= lb2_q;
        end
    end

    assign hb_edge = hb2_q & ~hb3_q;
    assign lb_edge = lb2_q & ~lb3_q;

    // ==========================================================
    // path and divisor from the first control word
    always_comb begin
        if (ctrl1_q.prescaler_path_select) begin
            cfg.path = plpd_pkg::PLPD_PATH_HIGH;
        end else if (ctrl1_q.swallow_mode_select) begin
            cfg.path = plpd_pkg::PLPD_PATH_SWALLOW;
        end else begin
            cfg.path = plpd_pkg::PLPD_PATH_DIRECT;
        end
        if (cfg.path == plpd_pkg::PLPD_PATH_DIRECT) begin
            // low four setting bits are ignored, 12-bit divisor
            cfg.divisor = {4'h0, ctrl1_q.setting[15:4]};
            if (cfg.divisor < `PLPD_DIRECT_MIN) begin
                cfg.divisor = `PLPD_DIRECT_MIN;
            end
        end else begin
            cfg.divisor = ctrl1_q.setting;
            if (cfg.divisor < `PLPD_SWALLOW_MIN) begin
                cfg.divisor = `PLPD_SWALLOW_MIN;
            end
        end
    end

    // ==========================================================
    // divide-by-two prescaler on the high band input
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pre_q <= 1'b0;
        end else if (cfg.path != plpd_pkg::PLPD_PATH_HIGH) begin
            pre_q <= 1'b0;
        end else if (hb_edge) begin
            pre_q <= ~pre_q;
        end
    end

    // count tick of the selected path
    always_comb begin
        unique case (cfg.path)
            plpd_pkg::PLPD_PATH_HIGH: tick = hb_edge & pre_q;
            plpd_pkg::PLPD_PATH_SWALLOW: tick = lb_edge;
            plpd_pkg::PLPD_PATH_DIRECT: tick = lb_edge;
            default: tick = 1'b0;
        endcase
    end

    plpd_divider u_div (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .tick(tick),
        .divisor(cfg.divisor),
        .pulse(pulse)
    );

    assign div_pulse = pulse;

    // pulses seen since reset
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pulse_cnt_q <= 32'h00000000;
        end else if (pulse) begin
            pulse_cnt_q <= pulse_cnt_q + 32'h00000001;
        end
    end

    // ==========================================================
    // apb slave, zero wait states
    assign apb_wr = psel & penable & pwrite;
    assign apb_rd = psel & penable & ~pwrite;
    assign pready = 1'b1;

    always_comb begin
        mapped = 1'b1;
        rdata_d = 32'h00000000;
        unique case (paddr)
            `PLPD_REG_CTRL1: rdata_d = {8'h00, ctrl1_q};
            `PLPD_REG_CTRL2: rdata_d = {8'h00, ctrl2_q};
            `PLPD_REG_OUTWORD: rdata_d = {8'h00, out_word_q};
            `PLPD_REG_STATIN: rdata_d = {28'h0000000, statin_q};
            `PLPD_REG_DIVCFG: rdata_d = {frames_q, 6'h00, cfg};
            `PLPD_REG_PULSES: rdata_d = pulse_cnt_q;
            default: mapped = 1'b0;
        endcase
    end

    assign prdata = apb_rd ? rdata_d : 32'h00000000;
    assign pslverr = psel & penable & ~mapped;

    // software written words
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            out_word_q <= 24'h000000;
            statin_q <= 4'h0;
        end else if (apb_wr) begin
            if (paddr == `PLPD_REG_OUTWORD) begin
                out_word_q <= pwdata[23:0];
            end
            if (paddr == `PLPD_REG_STATIN) begin
                statin_q <= pwdata[3:0];
            end
        end
    end

endmodule
`default_nettype wire

// *** plpd_defines.svh ***
// How it works
// - path bit 1: high band, halve, swallow
// - high band setting 272..65535, ratio doubled
// - path bit 0 selects low band input
// - swallow mode 1: low band, exact 272..65535
// - swallow mode 0: 12-bit direct, 4..4095
// - serial clock times input and output data
// - function field picks serial output content
// - reset loads defined control defaults
// - 8-bit address picks input or output mode
`ifndef PLPD_DEFINES_SVH
`define PLPD_DEFINES_SVH

// ==========================================================
// serial link addresses, label form {B3..B0, A3..A0}
`define PLPD_ADDR_IN1 8'h82
`define PLPD_ADDR_IN2 8'h92
`define PLPD_ADDR_OUT 8'hA2
`define PLPD_DATA_BITS 5'h18
`define PLPD_DATA_LAST 5'h17

// ==========================================================
// second control word field positions
`define PLPD_IN2_DOC_LSB 9
`define PLPD_IN2_DOC_MSB 11

// ==========================================================
// divisor limits
`define PLPD_SWALLOW_MIN 16'h0110
`define PLPD_DIRECT_MIN 16'h0004

// ==========================================================
// reset values
`define PLPD_CTRL1_RST 24'h080000
`define PLPD_CTRL2_RST 24'h000000

// ==========================================================
// out pin function codes
`define PLPD_DOC_UNLOCK 3'h1
`define PLPD_DOC_DONE 3'h2
`define PLPD_DOC_LPIN 3'h4
`define PLPD_DOC_IOPIN 3'h5

// ==========================================================
// apb register byte offsets
`define PLPD_REG_CTRL1 12'h000
`define PLPD_REG_CTRL2 12'h004
`define PLPD_REG_OUTWORD 12'h008
`define PLPD_REG_STATIN 12'h00C
`define PLPD_REG_DIVCFG 12'h010
`define PLPD_REG_PULSES 12'h014

`endif

// *** plpd_pkg.sv ***
package plpd_pkg;

    // first control word, msb first
    typedef struct packed {
        logic [3:0] ref_sel;
        logic xtal_sel;
        logic count_en;
        logic prescaler_path_select;
        logic swallow_mode_select;
        logic [15:0] setting;
    } plpd_ctrl1_t;

    // divider path
    typedef enum logic [1:0] {
        PLPD_PATH_HIGH,
        PLPD_PATH_SWALLOW,
        PLPD_PATH_DIRECT
    } plpd_path_t;

    // divider configuration
    typedef struct packed {
        plpd_path_t path;
        logic [15:0] divisor;
    } plpd_divcfg_t;

    // software status inputs for the out pin
    typedef struct packed {
        logic io_pin;
        logic low_pin;
        logic count_done;
        logic unlock;
    } plpd_statin_t;

endpackage

// *** plpd_divider.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "plpd_defines.svh"

module plpd_divider (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic tick,
    input wire logic [15:0] divisor,
    output logic pulse
);

    logic [15:0] cnt_q;

    // ==========================================================
    // down counter, reload at end of each full count
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cnt_q <= 16'h0000;
            pulse <= 1'b0;
        end else begin
            pulse <= 1'b0;
            if (tick) begin
                if (cnt_q <= 16'h0001) begin
                    cnt_q <= divisor;
                    pulse <= 1'b1;
                end else begin
                    cnt_q <= cnt_q - 16'h0001;
                end
            end
        end
    end

endmodule
`default_nettype wire

// *** plpd_top_sva.sv ***
`timescale 1ns/10ps
`default_nettype none
// ====
// port checker
module plpd_top_sva (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic high_band_osc_input,
    input wire logic low_band_osc_input,
    input wire logic serial_clock_pin,
    input wire logic chip_enable_pin,
    input wire logic serial_in_pin,
    input wire logic serial_out_o,
    input wire logic serial_out_oe_n,
    input wire logic div_pulse
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);
    // outputs idle at release
    property p_rst_out;
        $fell(sys_rst) |-> serial_out_oe_n && !div_pulse && !pslverr;
    endproperty
    a_rst_out: assert property (p_rst_out)
        else $error("outputs busy after reset");
    // pulses are single and spaced
    property p_gap;
        div_pulse |=> !div_pulse [*3];
    endproperty
    a_gap: assert property (p_gap)
        else $error("divider pulses too close");
    // no pulse without oscillator edges
    property p_quiet;
        $stable({high_band_osc_input, low_band_osc_input}) [*8] |-> !div_pulse;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("pulse with no input edges");
    // out pin steady while nothing feeds it
    property p_oe_quiet;
        (!chip_enable_pin && !psel) [*8] |-> $stable(serial_out_oe_n);
    endproperty
    a_oe_quiet: assert property (p_oe_quiet)
        else $error("out pin moved while idle");
    // open drain never drives high
    property p_od;
        !serial_out_o;
    endproperty
    a_od: assert property (p_od)
        else $error("out pin driven high");
    // zero wait answer
    property p_ready;
        psel && penable |-> pready;
    endproperty
    a_ready: assert property (p_ready)
        else $error("no ready in access");
    // read data only in access phase
    property p_rd_idle;
        !(psel && penable) |-> prdata == 32'h00000000 && !pslverr;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("bus output outside access");
    // unmapped access flagged
    property p_err;
        psel && penable && paddr > 12'h014 |-> pslverr;
    endproperty
    a_err: assert property (p_err)
        else $error("unmapped access not flagged");
endmodule

bind plpd_top plpd_top_sva u_sva (.*);
`default_nettype wire

// *** plpd_far_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// ====
// controller and oscillators
module plpd_far_model (
    output logic serial_clock_pin,
    output logic chip_enable_pin,
    output logic serial_in_pin,
    output logic high_band_osc_input,
    output logic low_band_osc_input,
    input wire logic serial_out_oe_n
);
    // all lines quiet, link clock stopped
    initial begin
        serial_clock_pin = 1'b0;
        chip_enable_pin = 1'b0;
        serial_in_pin = 1'b0;
        high_band_osc_input = 1'b0;
        low_band_osc_input = 1'b0;
    end
    // one bit, data set low, pin sampled before rise, 48 ns period
    task automatic bitclk(input logic b, output logic s);
        serial_in_pin = b;
        #24;
        s = serial_out_oe_n;
        serial_clock_pin = 1'b1;
        #24;
        serial_clock_pin = 1'b0;
    endtask
    task automatic idle(input int n);
        logic s;
        repeat (n) bitclk(1'b0, s);
    endtask
    // address b0 first, then 24 bits with enable high
    task automatic frame(input logic [7:0] a, input logic [23:0] d, output logic [23:0] rd);
        logic [7:0] o;
        logic s;
        o = {a[3:0], a[7:4]};
        rd = 24'h000000;
        chip_enable_pin = 1'b0;
        for (int i = 0; i < 8; i++) begin
            bitclk(o[i], s);
        end
        chip_enable_pin = 1'b1;
        for (int i = 0; i < 24; i++) begin
            bitclk(d[i], s);
            rd = {rd[22:0], s};
        end
        #24;
        chip_enable_pin = 1'b0;
        serial_in_pin = ~serial_in_pin;
    endtask
    // burst of n edges, 40 ns period, kept off the system clock edges
    task automatic osc(input logic hi, input int n);
        #3;
        repeat (n) begin
            high_band_osc_input = hi;
            low_band_osc_input = !hi;
            #20;
            high_band_osc_input = 1'b0;
            low_band_osc_input = 1'b0;
            #20;
        end
    endtask
endmodule
`default_nettype wire

// *** pll_programmable_divider_select_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "plpd_defines.svh"
// ====
// bench
module pll_programmable_divider_select_tb;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata, r, d;
    logic pready, pslverr, hb, lb, sck, ce, sdi, so, so_oe_n, div_pulse, e;
    logic [23:0] fr;
    int error_cnt = 0, total_checks = 0;
    always #5 clk_sys = ~clk_sys;
    plpd_top DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .high_band_osc_input(hb), .low_band_osc_input(lb),
        .serial_clock_pin(sck), .chip_enable_pin(ce), .serial_in_pin(sdi),
        .serial_out_o(so), .serial_out_oe_n(so_oe_n), .div_pulse(div_pulse));
    plpd_far_model m (.serial_clock_pin(sck), .chip_enable_pin(ce), .serial_in_pin(sdi),
        .high_band_osc_input(hb), .low_band_osc_input(lb), .serial_out_oe_n(so_oe_n));
    // ====
    // shared tasks
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task set1(input logic hi_path, input logic swal, input logic [15:0] st);
        m.frame(`PLPD_ADDR_IN1, {4'h0, 1'b1, 1'b0, hi_path, swal, st}, fr);
        repeat (8) @(posedge clk_sys);
        apb(1'b0, `PLPD_REG_DIVCFG, 32'h0);
    endtask
    // pulses over n edges, after one warm-up burst
    task cnt(input logic hi, input int n);
        logic [31:0] p;
        m.osc(hi, n);
        repeat (8) @(posedge clk_sys);
        apb(1'b0, `PLPD_REG_PULSES, 32'h0);
        p = r;
        m.osc(hi, n);
        repeat (8) @(posedge clk_sys);
        apb(1'b0, `PLPD_REG_PULSES, 32'h0);
        d = r - p;
    endtask
    // ====
    // scenarios
    task t_reset;
        apb(1'b0, `PLPD_REG_CTRL1, 32'h0);
        chk(r, 32'h00080000);
        apb(1'b0, `PLPD_REG_CTRL2, 32'h0);
        chk(r, 32'h00000000);
        apb(1'b0, `PLPD_REG_DIVCFG, 32'h0);
        chk(r[17:0], {plpd_pkg::PLPD_PATH_DIRECT, 16'h0004});
        chk(so_oe_n, 1'b1);
        $display("reset test done");
    endtask
    task t_high;
        set1(1'b1, 1'b0, 16'h012C);
        chk(r[17:0], {plpd_pkg::PLPD_PATH_HIGH, 16'h012C});
        cnt(1'b1, 600);
        chk(d, 32'h1);
        cnt(1'b0, 300);
        chk(d, 32'h0);
        $display("high band test done");
    endtask
    task t_swallow;
        set1(1'b0, 1'b1, 16'h0110);
        chk(r[17:0], {plpd_pkg::PLPD_PATH_SWALLOW, 16'h0110});
        cnt(1'b0, 272);
        chk(d, 32'h1);
        cnt(1'b1, 544);
        chk(d, 32'h0);
        $display("swallow test done");
    endtask
    task t_direct;
        set1(1'b0, 1'b0, 16'hFFF0);
        chk(r[17:0], {plpd_pkg::PLPD_PATH_DIRECT, 16'h0FFF});
        set1(1'b0, 1'b0, 16'h0050);
        chk(r[17:0], {plpd_pkg::PLPD_PATH_DIRECT, 16'h0005});
        cnt(1'b0, 5);
        chk(d, 32'h1);
        cnt(1'b1, 20);
        chk(d, 32'h0);
        $display("direct test done");
    endtask
    task t_refuse;
        set1(1'b0, 1'b1, 16'h1234);
        apb(1'b0, `PLPD_REG_CTRL1, 32'h0);
        chk(r, 32'h00091234);
        m.frame(8'h55, 24'hFFFFFF, fr);
        repeat (8) @(posedge clk_sys);
        apb(1'b0, `PLPD_REG_CTRL1, 32'h0);
        chk(r, 32'h00091234);
        apb(1'b0, `PLPD_REG_DIVCFG, 32'h0);
        chk(r[31:24], 8'h05);
        $display("address test done");
    endtask
    task t_doc;
        logic [3:0] s;
        logic x;
        for (int k = 0; k < 2; k++) begin
            s = k ? 4'hC : 4'h3;
            apb(1'b1, `PLPD_REG_STATIN, {28'h0, s});
            for (int c = 0; c < 8; c++) begin
                m.frame(`PLPD_ADDR_IN2, {12'h000, c[2:0], 9'h000}, fr);
                repeat (8) @(posedge clk_sys);
                x = (c == 1 && s[0]) || (c == 2 && s[1]) || (c == 4 && !s[2]);
                x = x || (c == 5 && !s[3]);
                chk(so_oe_n, !x);
            end
        end
        $display("out function test done");
    endtask
    task t_out;
        apb(1'b1, `PLPD_REG_OUTWORD, 32'h00A53C96);
        m.frame(`PLPD_ADDR_OUT, 24'h000000, fr);
        chk(fr, 24'hA53C96);
        chk(so, 1'b0);
        apb(1'b0, 12'h020, 32'h0);
        chk(e, 1'b1);
        $display("data out test done");
    endtask
    // ====
    // verdict
    task finish_test;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // main sequence, link clock runs during reset
    initial begin
        fork
            repeat (16) @(posedge clk_sys);
            m.idle(3);
        join
        sys_rst <= 1'b0;
        m.idle(3);
        t_reset;
        t_high;
        t_swallow;
        t_direct;
        t_refuse;
        t_doc;
        t_out;
        finish_test;
    end
    // watchdog
    initial begin
        #500000;
        error_cnt++;
        finish_test;
    end
endmodule
`default_nettype wire
